/* inc/odc_regs.svh */
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH
// register indexes
`define ODC_REG_OUT 3'h0
`define ODC_REG_MODE 3'h1
`define ODC_REG_OLEN 3'h2
`define ODC_REG_CFG 3'h3
`define ODC_REG_OLF 3'h4
`define ODC_REG_THF 3'h5
`define ODC_REG_GLF 3'h6
`define ODC_REG_OVS 3'h7
`define ODC_RST_BYTE 8'h00
// command codes
`define ODC_CMD_WR_OUT 7'h00
`define ODC_CMD_WR_MODE 7'h01
`define ODC_CMD_WR_OLEN 7'h02
`define ODC_CMD_WR_CFG 7'h03
`define ODC_CMD_READ 7'h20
`define ODC_CMD_STAT 7'h30
// config fields
`define ODC_CFG_WD_LO 0
`define ODC_CFG_WD_HI 1
`define ODC_CFG_JOIN_DW 2
`define ODC_CFG_JOIN_UP 3
`define ODC_CFG_SC_OFF 4
`define ODC_WD_SEL_OFF 2'h3
// global fault bits
`define ODC_GF_WARN 0
`define ODC_GF_VDD_UV 1
`define ODC_GF_V5_UV 2
`define ODC_GF_DIE_HOT 3
`define ODC_GF_CK_ERR 4
`define ODC_GF_DCDC 5
`define ODC_GF_CRC 6
`define ODC_GF_WD 7
// frame
`define ODC_FRAME_BITS 16
`define ODC_CHK_BITS 8
`define ODC_CRC_INIT 7'h7F
`define ODC_CRC_POLY 7'h37
// timing
`define ODC_CLK_NS 25
`define ODC_TICK_NS 1000000
`define ODC_STRETCH_MS 200
`define ODC_WD_MS_0 1200
`define ODC_WD_MS_1 600
`define ODC_WD_MS_2 200
`define ODC_SHORT_NS 100000
`endif

/* inc/odc_pkg.sv */
`include "odc_regs.svh"
package odc_pkg;
  typedef logic [7:0] odc_byte_t;
  typedef logic [15:0] odc_word_t;
  typedef enum logic [6:0] {
    ODC_WR_OUT = `ODC_CMD_WR_OUT,
    ODC_WR_MODE = `ODC_CMD_WR_MODE,
    ODC_WR_OLEN = `ODC_CMD_WR_OLEN,
    ODC_WR_CFG = `ODC_CMD_WR_CFG,
    ODC_READ = `ODC_CMD_READ,
    ODC_STAT = `ODC_CMD_STAT
  } odc_cmd_t;
endpackage : odc_pkg

/* rtl/odc_core.sv */
// Functional notes
// - command 0 writes output byte; 1 turns high side on, 0 off.
// - command 1 writes mode byte; 0 high-side switch, 1 push-pull.
// - command 2 writes open-load enable byte; detection works in high-side mode.
// - command 3 writes config; watchdog field picks one of three timeouts.
// - coupling bits disable push-pull; short bit keeps fault pin quiet.
// - command 0x20 reads register index; fault registers add real-time byte.
// - command 0x30 writes nothing and returns real-time status.
// - status response is eight fault bits then eight level or slow bits.
// - fault register bits set on event, cleared only by clear bit.
// - clear acts at select rise, skipped on transfer error.
// - serial plus command mode lets clear bit drop the fault latch.
// - open-load, thermal, die-heat and clock-error real-time faults in read responses are stretched to 200 ms.
// - parallel mode keeps output byte stored but outputs follow pins.
// - channel overheat turns both sides off; stretched and latched.
// - die overheat turns everything off and sets global bit 3.
// - open-load flags channels in high-side mode when enabled.
// - undervoltage turns all off, LEDs off, pin low; bits 0 to 2.
// - watchdog raises pin and bit 7; next select fall lowers it.
// - overcurrent gives slow mode, fault pulse 100 us, register 7 flag.
// - fault pin latched in serial command mode, otherwise real-time fault OR.
// - clear bit is the first bit shifted in, ahead of the command.
`timescale 1ns/100ps
`include "odc_regs.svh"
module odc_core #(
  parameter int unsigned TICK_CYC = `ODC_TICK_NS / `ODC_CLK_NS,
  parameter int unsigned STRETCH_MS = `ODC_STRETCH_MS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  // mode straps
  input wire logic SERIAL_SEL,
  input wire logic CMD_SEL,
  input wire logic CRC_EN,
  input wire logic LEVEL_SEL,
  // parallel channel inputs
  input wire logic [7:0] PAR_IN,
  // analog monitors
  input wire logic [7:0] TH_HOT,
  input wire logic [7:0] OL_LOW,
  input wire logic [7:0] SHORT_HI,
  input wire logic [7:0] OUT_OV,
  input wire logic [7:0] OUT_HI,
  input wire logic DIE_HOT,
  input wire logic VDD_UV,
  input wire logic V5_UV,
  input wire logic VDD_WARN,
  input wire logic DCDC_ILIM,
  // channel drivers
  output logic [7:0] HS_ON,
  output logic [7:0] LS_ON,
  output logic [7:0] SLOW_MODE,
  // indicators
  output logic [7:0] LED_STATE,
  output logic [7:0] LED_FAULT,
  output logic FAULT_N,
  output logic WD_FAULT,
  output logic CRC_ERR_N,
  output logic UV_N
);
  localparam int SW = 60;
  localparam logic [SW-1:0] SYNC_RST = 60'h0000_0000_0000_002;
  localparam logic [11:0] SHORT_CYC =
    12'((`ODC_SHORT_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS);
  localparam int NSTR = 18;

  function automatic logic [6:0] crc7(input logic [16:0] d);
    logic [6:0] c;
    logic fb;
    c = `ODC_CRC_INIT;
    for (int i = 16; i >= 0; i--) begin
      fb = c[6] ^ d[i];
      c = {c[5:0], 1'b0} ^ (fb ? `ODC_CRC_POLY : 7'h00);
    end
    return c;
  endfunction : crc7

  // three-stage pin sampling, change accepted once stages two and three agree
  logic [SW-1:0] s1_q, s2_q, s3_q, st_q, pin_raw;
  assign pin_raw = {DCDC_ILIM, VDD_WARN, V5_UV, VDD_UV, DIE_HOT, OUT_HI, OUT_OV,
    SHORT_HI, OL_LOW, TH_HOT, PAR_IN, LEVEL_SEL, CRC_EN, CMD_SEL, SERIAL_SEL,
    SDI, CS_N, SCLK};
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      st_q <= SYNC_RST;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q ^ s3_q));
    end
  end

  logic dcdc_s, warn_s, v5uv_s, vdduv_s, die_s, lvl_sel_s, crc_en_s, cmd_s, ser_s;
  logic sdi_s, csn_s, sclk_s;
  logic [7:0] outhi_s, ov_s, short_s, ol_s, th_s, par_s;
  assign {dcdc_s, warn_s, v5uv_s, vdduv_s, die_s, outhi_s, ov_s, short_s, ol_s,
    th_s, par_s, lvl_sel_s, crc_en_s, cmd_s, ser_s, sdi_s, csn_s, sclk_s} = st_q;

  logic sclk_p_q, csn_p_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_p_q <= 1'b0;
      csn_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      csn_p_q <= csn_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_p_q & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_p_q & ~csn_s;
  assign cs_fall = ~csn_s & csn_p_q;
  assign cs_rise = csn_s & ~csn_p_q;

  // millisecond tick shared by stretchers and watchdog
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // receive shift and clock count
  logic [23:0] rx_q;
  logic [2:0] mod_q;
  logic [4:0] cnt_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_q <= 24'h000000;
      mod_q <= 3'h0;
      cnt_q <= 5'h00;
    end else if (cs_fall) begin
      mod_q <= 3'h0;
      cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      rx_q <= {rx_q[22:0], sdi_s};
      mod_q <= mod_q + 3'h1;
      if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
    end
  end

  // frame decode, last bits of the transfer belong to this device
  logic [7:0] f_cmd, f_dat, f_chk;
  logic ck_err, crc_bad, enough, frame_ok, zbit, do_clr, wr_ok;
  always_comb begin
    if (crc_en_s) begin
      f_cmd = rx_q[23:16];
      f_dat = rx_q[15:8];
      f_chk = rx_q[7:0];
    end else begin
      f_cmd = rx_q[15:8];
      f_dat = rx_q[7:0];
      f_chk = 8'h00;
    end
  end
  assign ck_err = (mod_q != 3'h0);
  assign crc_bad = crc_en_s & ~ck_err &
    (~f_chk[7] | (f_chk[6:0] != crc7({f_cmd, f_dat, 1'b1})));
  assign enough = (cnt_q >= 5'(`ODC_FRAME_BITS + (crc_en_s ? `ODC_CHK_BITS : 0)));
  assign frame_ok = enough & ~ck_err & ~crc_bad;
  assign zbit = f_cmd[7];
  assign do_clr = cs_rise & cmd_s & zbit & frame_ok;
  assign wr_ok = cs_rise & cmd_s & frame_ok;

  // settings registers
  logic [7:0] out_q, mode_q, olen_q, cfg_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_q <= `ODC_RST_BYTE;
      mode_q <= `ODC_RST_BYTE;
      olen_q <= `ODC_RST_BYTE;
      cfg_q <= `ODC_RST_BYTE;
    end else if (wr_ok) begin
      case (f_cmd[6:0])
        `ODC_CMD_WR_OUT: out_q <= f_dat;
        `ODC_CMD_WR_MODE: mode_q <= f_dat;
        `ODC_CMD_WR_OLEN: olen_q <= f_dat;
        `ODC_CMD_WR_CFG: cfg_q <= {3'h0, f_dat[4:0]};
        default: ;
      endcase
    end
  end

  logic coupled, sc_quiet, uv_any;
  logic [7:0] pp_eff, ol_rt, val;
  assign coupled = cfg_q[`ODC_CFG_JOIN_UP] | cfg_q[`ODC_CFG_JOIN_DW];
  assign sc_quiet = cfg_q[`ODC_CFG_SC_OFF];
  assign pp_eff = coupled ? 8'h00 : mode_q;
  assign ol_rt = ol_s & olen_q & ~pp_eff;
  assign val = ser_s ? out_q : par_s;
  assign uv_any = vdduv_s | v5uv_s;

  // channel drive; thermal, die heat and undervoltage force both sides off
  logic [7:0] off;
  assign off = th_s | {8{die_s | uv_any}};
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      HS_ON <= 8'h00;
      LS_ON <= 8'h00;
      SLOW_MODE <= 8'h00;
      UV_N <= 1'b1;
    end else begin
      HS_ON <= val & ~off;
      LS_ON <= pp_eff & ~val & ~off;
      SLOW_MODE <= short_s;
      UV_N <= ~uv_any;
    end
  end

  // stretchers: a short blip still reads high for the full window
  logic ck_ev;
  logic [NSTR-1:0] str_in, str_out;
  logic [7:0] str_cnt_q [0:NSTR-1];
  assign ck_ev = cs_rise & ck_err;
  assign str_in = {ck_ev, die_s, th_s, ol_rt};
  generate
    for (genvar g = 0; g < NSTR; g++) begin : g_str
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) str_cnt_q[g] <= 8'h00;
        else if (str_in[g]) str_cnt_q[g] <= 8'(STRETCH_MS + 1);
        else if (tick && str_cnt_q[g] != 8'h00) str_cnt_q[g] <= str_cnt_q[g] - 8'h01;
      end
      assign str_out[g] = str_in[g] | (str_cnt_q[g] != 8'h00);
    end
  endgenerate
  logic [7:0] ol_str, th_str;
  logic ck_str, die_str;
  assign {ck_str, die_str, th_str, ol_str} = str_out;

  // watchdog on select activity
  logic [10:0] wd_ms_q, wd_lim;
  logic wd_q, wd_en;
  always_comb begin
    case (cfg_q[`ODC_CFG_WD_HI:`ODC_CFG_WD_LO])
      2'h0: wd_lim = 11'(`ODC_WD_MS_0);
      2'h1: wd_lim = 11'(`ODC_WD_MS_1);
      2'h2: wd_lim = 11'(`ODC_WD_MS_2);
      default: wd_lim = 11'h7FF;
    endcase
  end
  assign wd_en = (cfg_q[`ODC_CFG_WD_HI:`ODC_CFG_WD_LO] != `ODC_WD_SEL_OFF);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wd_ms_q <= 11'h000;
      wd_q <= 1'b0;
    end else if (cs_fall) begin
      wd_ms_q <= 11'h000;
      wd_q <= 1'b0;
    end else begin
      if (tick && wd_ms_q != 11'h7FF) wd_ms_q <= wd_ms_q + 11'h001;
      if (wd_en && wd_ms_q >= wd_lim) wd_q <= 1'b1;
    end
  end
  assign WD_FAULT = wd_q;

  // crc error indicator, refreshed at each select rise ending a long enough frame with no clock count error
  logic crc_error_indicator_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) crc_error_indicator_q <= 1'b0;
    else if (cs_rise && enough && !ck_err) crc_error_indicator_q <= crc_bad;
  end
  assign CRC_ERR_N = ~crc_error_indicator_q;

  // latched fault registers; a new event beats a clear in the same cycle
  logic [7:0] olf_q, thf_q, glf_q, g_rt, g_ev;
  assign g_rt = {wd_q, crc_error_indicator_q, dcdc_s, ck_str, die_str, v5uv_s, vdduv_s, warn_s};
  assign g_ev = {wd_q, cs_rise & crc_bad, dcdc_s, ck_ev, die_s, v5uv_s, vdduv_s,
    warn_s};
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      olf_q <= `ODC_RST_BYTE;
      thf_q <= `ODC_RST_BYTE;
      glf_q <= `ODC_RST_BYTE;
    end else begin
      olf_q <= (do_clr ? 8'h00 : olf_q) | ol_str;
      thf_q <= (do_clr ? 8'h00 : thf_q) | th_str;
      glf_q <= (do_clr ? 8'h00 : glf_q) | g_ev;
    end
  end

  // overcurrent fault pulse
  logic [7:0] short_p_q;
  logic [11:0] sc_cnt_q;
  logic sc_new, sc_act;
  assign sc_new = |(short_s & ~short_p_q);
  assign sc_act = (sc_cnt_q != 12'h000);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      short_p_q <= 8'h00;
      sc_cnt_q <= 12'h000;
    end else begin
      short_p_q <= short_s;
      if (sc_new && !sc_quiet) sc_cnt_q <= SHORT_CYC;
      else if (sc_act) sc_cnt_q <= sc_cnt_q - 12'h001;
    end
  end

  // fault pin: irq latch in serial command mode, real-time OR elsewhere
  logic flt_rt, latched_mode, irq_q;
  assign flt_rt = (|th_str) | (|ol_str) | die_str | ck_str;
  assign latched_mode = ser_s & cmd_s;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) irq_q <= 1'b0;
    else irq_q <= (do_clr ? 1'b0 : irq_q) | flt_rt | ck_ev;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) FAULT_N <= 1'b1;
    else FAULT_N <= ~((latched_mode ? irq_q : flt_rt) | sc_act);
  end

  // indicator LEDs dark under undervoltage
  logic [7:0] f_bits, l_bits;
  assign f_bits = th_s | ol_rt;
  assign l_bits = lvl_sel_s ? short_s : outhi_s;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LED_STATE <= 8'h00;
      LED_FAULT <= 8'h00;
    end else begin
      LED_STATE <= uv_any ? 8'h00 : val;
      LED_FAULT <= uv_any ? 8'h00 : f_bits;
    end
  end

  // response word for the next transfer
  logic [15:0] resp_n, resp_q;
  always_comb begin
    resp_n = {f_bits, l_bits};
    if (cmd_s && f_cmd[6:0] == `ODC_CMD_READ) begin
      case (f_dat[2:0])
        `ODC_REG_OUT: resp_n = {8'h00, out_q};
        `ODC_REG_MODE: resp_n = {8'h00, mode_q};
        `ODC_REG_OLEN: resp_n = {8'h00, olen_q};
        `ODC_REG_CFG: resp_n = {8'h00, cfg_q};
        `ODC_REG_OLF: resp_n = {ol_str, olf_q};
        `ODC_REG_THF: resp_n = {th_str, thf_q};
        `ODC_REG_GLF: resp_n = {g_rt, glf_q};
        default: resp_n = {ov_s | short_s, 8'h00};
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) resp_q <= 16'h0000;
    else if (cs_rise) resp_q <= resp_n;
  end

  // transmit; tail bits pass the received stream on for chaining
  logic [23:0] tx_q;
  logic [23:0] tx_ld;
  assign tx_ld = crc_en_s ? {resp_q, crc_error_indicator_q, 7'h00} : {8'h00, resp_q};
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_q <= 24'h000000;
      SDO <= 1'b0;
    end else if (cs_fall) begin
      tx_q <= tx_ld;
      SDO <= crc_en_s ? tx_ld[23] : tx_ld[15];
    end else if (sclk_fall) begin
      tx_q <= {tx_q[22:0], rx_q[0]};
      SDO <= crc_en_s ? tx_q[22] : tx_q[14];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  clear_wins_a: assert property (do_clr |=> thf_q == $past(th_str))
    else $error("thermal register not cleared to live events");
  sticky_flt_a: assert property (!do_clr |=> (olf_q & $past(olf_q)) == $past(olf_q))
    else $error("open-load bit lost without clear");
  clr_blocked_a: assert property (cs_rise && (ck_err || crc_bad) |=>
    (glf_q & $past(glf_q)) == $past(glf_q))
    else $error("fault register cleared on bad transfer");
  ck_error_a: assert property (cs_rise && ck_err |=> glf_q[4] && out_q == $past(out_q)
    ##1 !FAULT_N)
    else $error("clock count error not flagged");
  par_follow_a: assert property (!ser_s |=> (HS_ON & ~$past(par_s)) == 8'h00)
    else $error("output followed register in parallel mode");
  all_off_a: assert property (die_s || uv_any |=> HS_ON == 8'h00 && LS_ON == 8'h00)
    else $error("channels not off on global fault");
  uv_pin_a: assert property (uv_any |=> !UV_N && LED_STATE == 8'h00)
    else $error("undervoltage not shown");
  coupled_pp_a: assert property (coupled && $stable(cfg_q) |=> LS_ON == 8'h00)
    else $error("push-pull active while coupled");
  wd_drop_a: assert property (cs_fall |=> !WD_FAULT ##1 glf_q[7] == $past(glf_q[7]))
    else $error("watchdog not released at select fall");
  sc_pulse_a: assert property (sc_new && !sc_quiet |=> sc_act [*8] ##1 !FAULT_N)
    else $error("short pulse not held");
  th_stretch_a: assert property ($fell(th_s[0]) |-> th_str[0] [*8])
    else $error("thermal not stretched");
  resp_cap_a: assert property (cs_rise && f_cmd[6:0] == `ODC_CMD_STAT |=>
    resp_q == $past({f_bits, l_bits}))
    else $error("status response not captured");
endmodule : odc_core

/* tb/odc_host.sv */
`timescale 1ns/100ps
module odc_host (
  // clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // sdo sampled late in the high phase: the device moves it a few clocks after each fall
  // frames up to 24 bits, sent from bit nb-1 down, so the check byte rides along
  task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx);
    rx = 24'h000000;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      sdi <= tx[nb - 1 - i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rx = {rx[22:0], sdo};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // released line must not keep looking valid
    sdi <= ~sdi;
    repeat (10) @(posedge clk);
  endtask : xfer
endmodule : odc_host

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int TK = 20;
  localparam int ST = 20;
  logic clk;
  logic resetn;
  logic serial_sel, cmd_sel, crc_en, level_sel;
  logic die_hot, vdd_uv, v5_uv, vdd_warn, dcdc_ilim;
  logic [7:0] par_in, th_hot, ol_low, short_hi, out_ov, out_hi;
  wire logic sclk, cs_n, sdi, sdo;
  wire logic [7:0] hs_on, ls_on, slow_mode, led_state, led_fault;
  wire logic fault_n, wd_fault, crc_err_n, uv_n;
  logic [31:0] seed = 32'h5E1A;
  int fails = 0;
  int check_count = 0;
  odc_pkg::odc_byte_t regs [4];

  odc_core #(.TICK_CYC(TK), .STRETCH_MS(ST)) DUT (
    .CLK(clk), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
    .SERIAL_SEL(serial_sel), .CMD_SEL(cmd_sel), .CRC_EN(crc_en), .LEVEL_SEL(level_sel),
    .PAR_IN(par_in), .TH_HOT(th_hot), .OL_LOW(ol_low), .SHORT_HI(short_hi),
    .OUT_OV(out_ov), .OUT_HI(out_hi), .DIE_HOT(die_hot), .VDD_UV(vdd_uv), .V5_UV(v5_uv),
    .VDD_WARN(vdd_warn), .DCDC_ILIM(dcdc_ilim), .HS_ON(hs_on), .LS_ON(ls_on),
    .SLOW_MODE(slow_mode), .LED_STATE(led_state), .LED_FAULT(led_fault),
    .FAULT_N(fault_n), .WD_FAULT(wd_fault), .CRC_ERR_N(crc_err_n), .UV_N(uv_n)
  );
  odc_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic odc_pkg::odc_byte_t rnd8();
    for (int i = 0; i < 8; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    end
    return seed[7:0];
  endfunction : rnd8

  // high side follows the bit, low side only where push-pull is chosen
  function automatic odc_pkg::odc_word_t exp_drive(input odc_pkg::odc_byte_t o,
    input odc_pkg::odc_byte_t md);
    return {o, ~o & md};
  endfunction : exp_drive

  // check sequence over command, data and the leading one of the check byte
  function automatic logic [6:0] check_sequence(input logic [16:0] v);
    logic [6:0] c;
    c = 7'h7F;
    for (int i = 16; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((c[6] ^ v[i]) ? 7'h37 : 7'h00);
    end
    return c;
  endfunction : check_sequence

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input odc_pkg::odc_word_t got, input odc_pkg::odc_word_t exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic z, input logic [6:0] code, input odc_pkg::odc_byte_t d,
    output odc_pkg::odc_word_t rx);
    logic [23:0] r;
    host.xfer({8'h00, z, code, d}, 16, r);
    rx = r[15:0];
  endtask : cmd

  // a read needs a second frame to bring its answer out
  task automatic rd(input logic [2:0] idx, output odc_pkg::odc_word_t pre,
    output odc_pkg::odc_word_t rx);
    logic [23:0] r;
    host.xfer({9'h000, odc_pkg::ODC_READ, 5'h00, idx}, 16, r);
    pre = r[15:0];
    host.xfer({9'h000, odc_pkg::ODC_STAT, 8'h00}, 16, r);
    rx = r[15:0];
  endtask : rd

  task automatic set_src(input int i, input odc_pkg::odc_byte_t m);
    @(posedge clk);
    case (i)
      0: ol_low <= m;
      1: th_hot <= m;
      2: vdd_warn <= m[0];
      3: vdd_uv <= m[0];
      4: v5_uv <= m[0];
      5: die_hot <= m[0];
      default: dcdc_ilim <= m[0];
    endcase
  endtask : set_src

  initial begin
    odc_pkg::odc_word_t rx;
    odc_pkg::odc_word_t pre;
    odc_pkg::odc_byte_t d;
    odc_pkg::odc_byte_t m;
    odc_pkg::odc_byte_t g;
    logic [2:0] ri;
    logic [23:0] r24;
    int n;
    resetn <= 1'b0;
    {serial_sel, cmd_sel, crc_en, level_sel} <= 4'hC;
    {die_hot, vdd_uv, v5_uv, vdd_warn, dcdc_ilim} <= 5'h00;
    {par_in, th_hot, ol_low, short_hi, out_ov, out_hi} <= 48'h000000000000;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(3'(i), pre, rx);
      chk(rx, 16'h0000);
    end
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 4; i++) begin
        // join bits kept clear so push-pull stays predictable
        d = (i == 3) ? (rnd8() & 8'h13) : rnd8();
        regs[i] = d;
        @(posedge clk);
        level_sel <= d[5];
        out_hi <= rnd8();
        cmd(1'b0, 7'(i), d, rx);
        rd(3'(i), pre, rx);
        chk(pre, {8'h00, level_sel ? short_hi : out_hi});
        chk(rx, {8'h00, d});
      end
      repeat (8) @(posedge clk);
      chk({hs_on, ls_on}, exp_drive(regs[0], regs[1]));
    end
    cmd(1'b0, 7'h01, 8'h00, rx);
    cmd(1'b0, 7'h02, 8'hFF, rx);
    cmd(1'b0, 7'h03, 8'h03, rx);
    regs[1] = 8'h00;
    for (int i = 0; i < 7; i++) begin
      m = 8'h01 << (rnd8() & 8'h07);
      ri = (i < 2) ? 3'(i + 4) : 3'h6;
      g = (i < 2) ? m : (i < 6) ? 8'h01 << (i - 2) : 8'h20;
      set_src(i, (i < 2) ? m : 8'hFF);
      repeat (20) @(posedge clk);
      if (i < 2) begin
        cmd(1'b0, 7'h30, 8'h00, rx);
        cmd(1'b0, 7'h30, 8'h00, rx);
        chk({8'h00, rx[15:8]}, {8'h00, m});
        chk({8'h00, led_fault}, {8'h00, m});
      end
      if (i == 1) chk({8'h00, (hs_on | ls_on) & m}, 16'h0000);
      if (i == 5) chk({hs_on, ls_on}, 16'h0000);
      if (i == 3) chk({led_state, 7'h00, uv_n}, 16'h0000);
      set_src(i, 8'h00);
      rd(ri, pre, rx);
      chk({8'h00, rx[7:0] & g}, {8'h00, g});
      if (i < 2) chk({8'h00, rx[15:8] & m}, {8'h00, m});
      if (i < 2 || i == 5) chk({15'h0000, fault_n}, 16'h0000);
      // stretched sources would win over the clear
      repeat (25 * TK) @(posedge clk);
      cmd(1'b1, 7'h30, 8'h00, rx);
      rd(ri, pre, rx);
      chk({8'h00, rx[7:0] & g}, 16'h0000);
      chk({15'h0000, fault_n}, 16'h0001);
    end
    set_src(1, 8'h01);
    repeat (20) @(posedge clk);
    set_src(1, 8'h00);
    repeat (25 * TK) @(posedge clk);
    d = hs_on;
    host.xfer({12'h000, 1'b1, 7'h00, ~regs[0][7:4]}, 12, r24);
    chk({hs_on, 7'h00, fault_n}, {d, 8'h00});
    rd(3'h5, pre, rx);
    chk({8'h00, rx[7:0]}, 16'h0001);
    rd(3'h6, pre, rx);
    chk({8'h00, rx[7:0] & 8'h10}, 16'h0010);
    repeat (25 * TK) @(posedge clk);
    cmd(1'b1, 7'h30, 8'h00, rx);
    chk({15'h0000, fault_n}, 16'h0001);
    cmd(1'b0, 7'h03, 8'h02, rx);
    n = 0;
    while (wd_fault !== 1'b1 && n < 300 * TK) begin
      @(posedge clk);
      n++;
    end
    if (n == 300 * TK) begin
      fails++;
      wrap_up();
    end
    chk({15'h0000, n > 190 * TK && n < 200 * TK}, 16'h0001);
    rd(3'h6, pre, rx);
    chk({wd_fault, 7'h00, rx[7:0] & 8'h80}, 16'h0080);
    cmd(1'b0, 7'h03, 8'h03, rx);
    d = rnd8();
    @(posedge clk);
    serial_sel <= 1'b0;
    par_in <= d;
    cmd(1'b0, 7'h00, ~d, rx);
    repeat (8) @(posedge clk);
    chk({hs_on, ls_on}, exp_drive(d, regs[1]));
    serial_sel <= 1'b1;
    m = 8'h01 << (rnd8() & 8'h07);
    @(posedge clk);
    short_hi <= m;
    out_ov <= rnd8();
    repeat (10) @(posedge clk);
    chk({slow_mode, 7'h00, fault_n}, {m, 8'h00});
    rd(3'h7, pre, rx);
    chk(rx, {out_ov | m, 8'h00});
    // coupled pairs must never drive the low side
    cmd(1'b0, 7'h03, 8'h0F, rx);
    cmd(1'b0, 7'h01, 8'hFF, rx);
    cmd(1'b0, 7'h00, 8'h00, rx);
    repeat (8) @(posedge clk);
    chk({hs_on, ls_on}, 16'h0000);
    cmd(1'b0, 7'h01, 8'h00, rx);
    cmd(1'b0, 7'h03, 8'h03, rx);
    // corrupt check byte leaves the outputs alone and pulls the error pin low
    @(posedge clk);
    crc_en <= 1'b1;
    repeat (8) @(posedge clk);
    d = rnd8() | 8'h01;
    host.xfer({8'h00, d, 1'b1, check_sequence({8'h00, d, 1'b1}) ^ 7'h01}, 24, r24);
    chk({hs_on, 7'h00, crc_err_n}, 16'h0000);
    host.xfer({8'h00, d, 1'b1, check_sequence({8'h00, d, 1'b1})}, 24, r24);
    chk({8'h00, r24[7:0]}, 16'h0080);
    chk({hs_on, 7'h00, crc_err_n}, {d, 8'h01});
    @(posedge clk);
    crc_en <= 1'b0;
    repeat (8) @(posedge clk);
    rd(3'h6, pre, rx);
    chk({8'h00, rx[7:0] & 8'h40}, 16'h0040);
    wrap_up();
  end
endmodule : testbench
